// ==== src/aabf_formatter.sv ====
// Aux pack and audio sample formatter with APB configuration
//
// The register addresses and the APB interface to the registers were left to the implementer.
`default_nettype none

// How it works
// - Time code latched per frame, repeated
// - Colour-frame and drop-frame bits from config
// - Polarity and user-group flag bits placed
// - Eight user groups, even nibble upper
// - User groups latched once per frame
// - Video aux blocks carry section 010
// - Fifteen packs plus two all-ones bytes
// - Pack index 0..44 selects content
// - Source packs at 39/40 even, 0/1 odd
// - Other aux pack slots all ones
// - No aux info gives all-ones pack
// - Rate bit and signal type code
// - Reserved pack bits driven to one
// - Copy free and 16:9 aspect codes
// - Delivery flags encode unit output order
// - Change flag zero on repeated picture
// - Audio blocks carry section 011
// - Five aux bytes then 72 data bytes
// - Eight 48 kHz 16-bit channels, separate
// - Emphasis indication defaults off
// - Sample 8000 hex becomes 8001 hex
// - Audio frame starts at line one
module aabf_formatter
    import aabf_pkg::*;
#(
    parameter int CHANNELS = AUDIO_CHANNELS
) (
    input  wire logic              clk_sys_in,
    input  wire logic              rst_n_in,
    // APB slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [APB_AW-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic                   pready_out,
    output logic                   pslverr_out,
    output logic      [31:0]       prdata_out,
    // Frame timing and per-frame content
    input  wire logic              frame_start_in,
    input  wire aabf_tc_type       timecode_in,
    input  wire logic [31:0]       user_groups_in,
    input  wire logic              picture_repeat_in,
    input  wire logic              line1_start_in,
    // Pack requests
    input  wire logic              pack_req_in,
    input  wire aabf_kind_type     pack_kind_in,
    input  wire logic [5:0]        pack_index_in,
    input  wire logic [3:0]        seq_num_in,
    output logic                   pack_valid_out,
    output logic      [39:0]       pack_data_out,
    output logic      [2:0]        pack_section_out,
    // Audio samples
    input  wire logic              sample_valid_in,
    input  wire logic [2:0]        sample_chan_in,
    input  wire logic [15:0]       sample_in,
    output logic                   audio_valid_out,
    output logic      [2:0]        audio_chan_out,
    output logic      [15:0]       audio_data_out,
    output logic                   audio_first_out,
    output logic                   audio_block_end_out,
    output logic      [2:0]        audio_section_out,
    output logic                   emphasis_out
);

    // Channel count is fixed by the section layout
    if (CHANNELS != AUDIO_CHANNELS) begin : g_chk
        $error("aabf_formatter: CHANNELS must be 8");
    end

    typedef struct packed {
        aabf_cfg_type    cfg;
        aabf_tc_type     tc_lat;
        logic [31:0]     ug_lat;
        logic            fc_lat;
        logic            pack_valid;
        logic [39:0]     pack_data;
        logic [2:0]      section;
        logic            audio_valid;
        logic [2:0]      audio_chan;
        logic [15:0]     audio_data;
        logic            audio_first;
        logic            block_end;
        logic [7:0][6:0] byte_cnt;
        logic [7:0]      line1_pend;
        logic [15:0]     subst_cnt;
        logic [15:0]     frame_cnt;
        logic [31:0]     prdata;
    } aabf_state_type;

    aabf_state_type st_r;
    aabf_state_type st_nxt;
    logic           rst_meta_r;
    logic           rst_sync_r;

    // Reset release through two flops; assert stays asynchronous
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Register bus decode
    logic apb_setup;
    logic apb_access;
    logic apb_mapped;
    assign apb_setup  = psel_in && !penable_in;
    assign apb_access = psel_in && penable_in;
    assign apb_mapped = (paddr_in == ADDR_CONFIG) ||
                        (paddr_in == ADDR_STATUS);
    // Zero wait states; read data is captured in the setup cycle
    assign pready_out  = 1'b1;
    assign pslverr_out = apb_access && !apb_mapped;

    // All next-state logic
    always_comb begin
        logic [39:0] pk;
        logic [4:0]  signal_type_field;
        logic [3:0]  seq_count;
        logic        seq_ok;
        logic        odd_seq;
        logic [5:0]  vs_idx;
        logic [5:0]  vsc_idx;
        logic [6:0]  cnt;
        pk        = PACK_EMPTY;
        signal_type_field     = SIGNAL_TYPE_FIELD_1080;
        seq_count = SEQ_COUNT_60;
        seq_ok    = 1'b0;
        odd_seq   = 1'b0;
        vs_idx    = VS_IDX_EVEN;
        vsc_idx   = VSC_IDX_EVEN;
        cnt       = 7'h00;
        st_nxt    = st_r;
        st_nxt.pack_valid  = 1'b0;
        st_nxt.audio_valid = 1'b0;
        st_nxt.audio_first = 1'b0;
        st_nxt.block_end   = 1'b0;

        // Per-frame capture keeps every pack in a frame identical
        if (frame_start_in) begin
            st_nxt.tc_lat    = timecode_in;
            st_nxt.ug_lat    = user_groups_in;
            st_nxt.fc_lat    = !picture_repeat_in;
            st_nxt.frame_cnt = st_r.frame_cnt + 16'h0001;
        end

        // Register writes are captured in the access cycle and apply from the next cycle
        if (apb_access && pwrite_in && paddr_in == ADDR_CONFIG) begin
            st_nxt.cfg = aabf_cfg_type'(pwdata_in[12:0]);
        end
        // Read data prepared in setup so it stands for the access
        if (apb_setup) begin
            case (paddr_in)
                ADDR_CONFIG: st_nxt.prdata = {19'h0, st_r.cfg};
                ADDR_STATUS: st_nxt.prdata = {st_r.frame_cnt,
                                              st_r.subst_cnt};
                default:     st_nxt.prdata = 32'h0000_0000;
            endcase
        end

        // Format selection
        seq_count = st_r.cfg.rate50 ? SEQ_COUNT_50 : SEQ_COUNT_60;
        if (st_r.cfg.lines720) begin
            signal_type_field = SIGNAL_TYPE_FIELD_720;
        end else if (st_r.cfg.active1035 && !st_r.cfg.rate50) begin
            signal_type_field = SIGNAL_TYPE_FIELD_1035;
        end else begin
            signal_type_field = SIGNAL_TYPE_FIELD_1080;
        end
        seq_ok  = seq_num_in < seq_count;
        odd_seq = seq_num_in[0];
        vs_idx  = odd_seq ? VS_IDX_ODD : VS_IDX_EVEN;
        vsc_idx = odd_seq ? VSC_IDX_ODD : VSC_IDX_EVEN;

        // Pack assembly; anything unassigned stays all ones
        case (pack_kind_in)
            KIND_TIMECODE: begin
                pk = {HDR_TIMECODE,
                      st_r.cfg.colour_sync, st_r.cfg.drop_frame,
                      st_r.tc_lat.fr_t, st_r.tc_lat.fr_u,
                      st_r.cfg.polarity,
                      st_r.tc_lat.sec_t, st_r.tc_lat.sec_u,
                      st_r.cfg.ug_flags[0],
                      st_r.tc_lat.min_t, st_r.tc_lat.min_u,
                      st_r.cfg.ug_flags[2], st_r.cfg.ug_flags[1],
                      st_r.tc_lat.hr_t, st_r.tc_lat.hr_u};
                st_nxt.section = SECT_SUBCODE;
            end
            KIND_USER_GROUP: begin
                // Group k sits in bits 4k-1..4k-4; byte one holds 2 and 1
                pk = {HDR_USERGRP, st_r.ug_lat[7:0], st_r.ug_lat[15:8],
                      st_r.ug_lat[23:16], st_r.ug_lat[31:24]};
                st_nxt.section = SECT_SUBCODE;
            end
            KIND_VIDEO_AUX_SECTION: begin
                st_nxt.section = SECT_VIDEO_AUX_SECTION;
                // Index above the last pack is a block's filler byte slot
                if (!st_r.cfg.video_aux_section_en || !seq_ok ||
                    pack_index_in > VIDEO_AUX_SECTION_LAST_IDX) begin
                    pk = PACK_EMPTY;
                end else if (pack_index_in == vs_idx) begin
                    pk = {HDR_VSOURCE, BYTE_FILL, BYTE_FILL,
                          2'b11, st_r.cfg.rate50, signal_type_field,
                          8'h7F};
                end else if (pack_index_in == vsc_idx) begin
                    pk = {HDR_VSCTRL,
                          COPY_FREE, 6'h3F,
                          2'b11, 2'b00, 1'b1, ASPECT_16_9,
                          st_r.cfg.ff, st_r.cfg.fs,
                          st_r.fc_lat, 5'h1C,
                          BYTE_FILL};
                end else begin
                    pk = PACK_EMPTY;
                end
            end
            KIND_AUDIO_AUX: begin
                // Aux pack contents belong to another block
                pk = PACK_EMPTY;
                st_nxt.section = SECT_AUDIO;
            end
            default: begin
                pk = PACK_EMPTY;
            end
        endcase
        if (pack_req_in) begin
            st_nxt.pack_valid = 1'b1;
            st_nxt.pack_data  = pk;
        end else begin
            st_nxt.section = st_r.section;
        end

        // Line one arms every channel; a sample arriving with it wins
        if (line1_start_in) begin
            st_nxt.line1_pend = 8'hFF;
        end
        if (sample_valid_in) begin
            st_nxt.audio_valid = 1'b1;
            st_nxt.audio_chan  = sample_chan_in;
            if (sample_in == SAMPLE_ERROR) begin
                st_nxt.audio_data = SAMPLE_SUBST;
                st_nxt.subst_cnt  = st_r.subst_cnt + 16'h0001;
            end else begin
                st_nxt.audio_data = sample_in;
            end
            if (line1_start_in || st_r.line1_pend[sample_chan_in]) begin
                st_nxt.audio_first = 1'b1;
                st_nxt.line1_pend[sample_chan_in] = 1'b0;
            end
            // Each channel counts its own block bytes
            cnt = st_r.byte_cnt[sample_chan_in] + BYTES_PER_SAMPLE;
            if (cnt >= 7'(AUDIO_DATA_BYTES)) begin
                st_nxt.block_end = 1'b1;
                st_nxt.byte_cnt[sample_chan_in] = 7'h00;
            end else begin
                st_nxt.byte_cnt[sample_chan_in] = cnt;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            st_r         <= '0;
            st_r.cfg     <= CFG_RESET;
            st_r.fc_lat  <= 1'b1;
            st_r.section <= SECT_SUBCODE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state, audio section code excepted
    assign prdata_out          = st_r.prdata;
    assign pack_valid_out      = st_r.pack_valid;
    assign pack_data_out       = st_r.pack_data;
    assign pack_section_out    = st_r.section;
    assign audio_valid_out     = st_r.audio_valid;
    assign audio_chan_out      = st_r.audio_chan;
    assign audio_data_out      = st_r.audio_data;
    assign audio_first_out     = st_r.audio_first;
    assign audio_block_end_out = st_r.block_end;
    assign audio_section_out   = SECT_AUDIO;
    assign emphasis_out        = st_r.cfg.emphasis;

    // Checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_sync_r);

    logic [1:0] seq_ok_h;
    assign seq_ok_h = {seq_num_in[0], 1'b0};

    AST_TC_FRAME: assert property (
        pack_req_in && pack_kind_in == KIND_TIMECODE && !frame_start_in
        ##1 pack_req_in && pack_kind_in == KIND_TIMECODE
        && !frame_start_in
        |=> pack_data_out == $past(pack_data_out)
        || $past(apb_access && pwrite_in, 2))
        else $error("time code changed within a frame");
    AST_TC_FLAGS: assert property (
        pack_req_in && pack_kind_in == KIND_TIMECODE
        |=> pack_data_out[31] == $past(st_r.cfg.colour_sync)
        && pack_data_out[30] == $past(st_r.cfg.drop_frame)
        && pack_data_out[39:32] == HDR_TIMECODE)
        else $error("time code flag bits wrong");
    AST_UG_MAP: assert property (
        frame_start_in ##1 (pack_req_in && !frame_start_in
        && pack_kind_in == KIND_USER_GROUP)
        |=> pack_data_out[31:0] == {$past(user_groups_in[7:0], 2),
                                    $past(user_groups_in[15:8], 2),
                                    $past(user_groups_in[23:16], 2),
                                    $past(user_groups_in[31:24], 2)})
        else $error("user group pack not the latched groups");
    AST_VIDEO_AUX_SECTION_SECT: assert property (
        pack_req_in && pack_kind_in == KIND_VIDEO_AUX_SECTION
        |=> pack_valid_out && pack_section_out == SECT_VIDEO_AUX_SECTION)
        else $error("video aux section code wrong");
    AST_EMPTY: assert property (
        pack_req_in && pack_kind_in == KIND_VIDEO_AUX_SECTION && !st_r.cfg.video_aux_section_en
        |=> pack_data_out == PACK_EMPTY)
        else $error("empty pack not all ones");
    AST_VS_POS: assert property (
        pack_req_in && pack_kind_in == KIND_VIDEO_AUX_SECTION && st_r.cfg.video_aux_section_en
        && seq_num_in < SEQ_COUNT_60
        && pack_index_in == (seq_num_in[0] ? 6'h00 : 6'h27)
        |=> pack_data_out[39:32] == HDR_VSOURCE)
        else $error("source pack misplaced");
    AST_VSC_FIELDS: assert property (
        pack_valid_out && pack_data_out[39:32] == HDR_VSCTRL
        |-> pack_data_out[31:30] == COPY_FREE
        && pack_data_out[18:16] == ASPECT_16_9)
        else $error("source control codes wrong");
    AST_SIGNAL_TYPE_FIELD: assert property (
        pack_valid_out && pack_data_out[39:32] == HDR_VSOURCE
        && $past(st_r.cfg.lines720)
        |-> pack_data_out[12:8] == SIGNAL_TYPE_FIELD_720)
        else $error("signal type code wrong");
    AST_SUBST: assert property (
        sample_valid_in && sample_in == SAMPLE_ERROR
        |=> audio_valid_out && audio_data_out == SAMPLE_SUBST)
        else $error("error code sample not replaced");
    AST_FIRST: assert property (
        line1_start_in ##1 !sample_valid_in ##1 sample_valid_in
        |=> audio_first_out)
        else $error("audio frame start not marked");

    COV_TC: cover property (pack_valid_out
        && pack_data_out[39:32] == HDR_TIMECODE);
    COV_VS_ODD: cover property (pack_req_in && pack_kind_in == KIND_VIDEO_AUX_SECTION
        && seq_ok_h[1] && pack_index_in == 6'h00);
    COV_SUBST: cover property (audio_valid_out
        && audio_data_out == SAMPLE_SUBST);
    COV_BLOCK: cover property (audio_block_end_out);

endmodule
`default_nettype wire

// ==== include/aabf_pkg.sv ====
// Constants, layouts and types of the aux and audio block formatter
`default_nettype none
package aabf_pkg;
    // Register map, byte addresses on the APB
    localparam logic [7:0]  ADDR_CONFIG   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam int          APB_AW        = 8;
    // Section codes carried in the block identifier
    localparam logic [2:0]  SECT_VIDEO_AUX_SECTION     = 3'h2;
    localparam logic [2:0]  SECT_AUDIO    = 3'h3;
    localparam logic [2:0]  SECT_SUBCODE  = 3'h1;
    // Pack headers
    localparam logic [7:0]  HDR_TIMECODE  = 8'h13;
    localparam logic [7:0]  HDR_USERGRP   = 8'h14;
    localparam logic [7:0]  HDR_VSOURCE   = 8'h60;
    localparam logic [7:0]  HDR_VSCTRL    = 8'h61;
    localparam logic [7:0]  BYTE_FILL     = 8'hFF;
    localparam logic [39:0] PACK_EMPTY    = 40'hFF_FFFF_FFFF;
    // Pack numbering inside one sequence
    localparam logic [5:0]  VIDEO_AUX_SECTION_LAST_IDX = 6'h2C;
    localparam logic [5:0]  VS_IDX_EVEN   = 6'h27;
    localparam logic [5:0]  VSC_IDX_EVEN  = 6'h28;
    localparam logic [5:0]  VS_IDX_ODD    = 6'h00;
    localparam logic [5:0]  VSC_IDX_ODD   = 6'h01;
    localparam int          VIDEO_AUX_SECTION_PACKS_PER_BLOCK = 15;
    localparam int          VIDEO_AUX_SECTION_RSV_BYTES       = 2;
    // Sequences per channel
    localparam logic [3:0]  SEQ_COUNT_60  = 4'hA;
    localparam logic [3:0]  SEQ_COUNT_50  = 4'hC;
    // Video signal type codes
    localparam logic [4:0]  SIGNAL_TYPE_FIELD_1080    = 5'h14;
    localparam logic [4:0]  SIGNAL_TYPE_FIELD_1035    = 5'h15;
    localparam logic [4:0]  SIGNAL_TYPE_FIELD_720     = 5'h18;
    // Source control constants
    localparam logic [1:0]  COPY_FREE     = 2'h0;
    localparam logic [2:0]  ASPECT_16_9   = 3'h2;
    // Audio section
    localparam int          AUDIO_AUX_BYTES  = 5;
    localparam int          AUDIO_DATA_BYTES = 72;
    localparam int          AUDIO_CHANNELS   = 8;
    localparam logic [15:0] SAMPLE_ERROR  = 16'h8000;
    localparam logic [15:0] SAMPLE_SUBST  = 16'h8001;
    localparam logic [6:0]  BYTES_PER_SAMPLE = 7'h02;

    typedef enum logic [1:0] {
        KIND_TIMECODE,
        KIND_USER_GROUP,
        KIND_VIDEO_AUX_SECTION,
        KIND_AUDIO_AUX
    } aabf_kind_type;

    typedef struct packed {
        logic [1:0] hr_t;
        logic [3:0] hr_u;
        logic [2:0] min_t;
        logic [3:0] min_u;
        logic [2:0] sec_t;
        logic [3:0] sec_u;
        logic [1:0] fr_t;
        logic [3:0] fr_u;
    } aabf_tc_type;

    typedef struct packed {
        logic       fs;
        logic       ff;
        logic       video_aux_section_en;
        logic       emphasis;
        logic [2:0] ug_flags;
        logic       polarity;
        logic       drop_frame;
        logic       colour_sync;
        logic       active1035;
        logic       lines720;
        logic       rate50;
    } aabf_cfg_type;

    // Delivery order 1 then 2, video aux on, emphasis off
    localparam aabf_cfg_type CFG_RESET = 13'h1C00;
endpackage
`default_nettype wire

// ==== dv/aabf_receiver.sv ====
// Receiver model that decodes the unit delivery order from packs
`default_nettype none
module aabf_receiver
    import aabf_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        pack_valid_in,
    input  wire logic [39:0] pack_data_in,
    output logic      [1:0]  first_unit_out,
    output logic      [1:0]  second_unit_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Only source control packs carry the order; others pass by
    always @(posedge clk_sys_in) begin
        if (pack_valid_in && pack_data_in[39:32] == HDR_VSCTRL) begin
            first_unit_out <= pack_data_in[14] ? 2'h1 : 2'h2;
            if (pack_data_in[15]) begin
                second_unit_out <= pack_data_in[14] ? 2'h2 : 2'h1;
            end else begin
                second_unit_out <= pack_data_in[14] ? 2'h1 : 2'h2;
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/aabf_formatter_test.sv ====
// Self-checking bench for the aux and audio block formatter
`default_nettype none
module aabf_formatter_test
    import aabf_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        aabf_kind_type k;
        logic [5:0]    i;
        logic [3:0]    s;
        logic [39:0]   e;
        logic [2:0]    c;
    } aabf_row_type;
    localparam logic [39:0] TCP  = 40'h13_E3D6_B492;
    localparam logic [39:0] UGP  = 40'h14_2143_6587;
    localparam logic [39:0] VSP  = 40'h60_FFFF_D47F;
    localparam logic [39:0] VSCP = 40'h61_3FCA_DCFF;
    localparam logic [39:0] EP   = PACK_EMPTY;
    localparam logic [2:0]  SV   = SECT_VIDEO_AUX_SECTION;
    // Plain cases: kind, index, sequence, expected pack, section
    localparam aabf_row_type ROWS[13] = '{
        '{KIND_USER_GROUP, 6'h00, 4'h0, UGP, SECT_SUBCODE},
        '{KIND_TIMECODE, 6'h00, 4'h0, TCP, SECT_SUBCODE},
        '{KIND_TIMECODE, 6'h00, 4'h1, TCP, SECT_SUBCODE},
        '{KIND_VIDEO_AUX_SECTION, VS_IDX_EVEN, 4'h0, VSP, SV},
        '{KIND_VIDEO_AUX_SECTION, VSC_IDX_EVEN, 4'h0, VSCP, SV},
        '{KIND_VIDEO_AUX_SECTION, VS_IDX_ODD, 4'h9, VSP, SV},
        '{KIND_VIDEO_AUX_SECTION, VSC_IDX_ODD, 4'h1, VSCP, SV},
        '{KIND_VIDEO_AUX_SECTION, 6'h00, 4'h0, EP, SV},
        '{KIND_VIDEO_AUX_SECTION, VS_IDX_EVEN, 4'h1, EP, SV},
        '{KIND_VIDEO_AUX_SECTION, VIDEO_AUX_SECTION_LAST_IDX, 4'h9, EP, SV},
        '{KIND_VIDEO_AUX_SECTION, 6'h2D, 4'h0, EP, SV},
        '{KIND_VIDEO_AUX_SECTION, VS_IDX_EVEN, 4'hA, EP, SV},
        '{KIND_AUDIO_AUX, 6'h03, 4'h0, EP, SECT_AUDIO}
    };
    localparam logic [2:0] MODES[5] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h3};
    localparam logic [4:0] STY[5] = '{SIGNAL_TYPE_FIELD_1080, SIGNAL_TYPE_FIELD_1035, SIGNAL_TYPE_FIELD_720,
                                      SIGNAL_TYPE_FIELD_1080, SIGNAL_TYPE_FIELD_720};
    logic          clk_sys = 1'b0;
    logic          rst_n = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic          frame_start = 1'b0;
    aabf_tc_type   tc = '0;
    logic [31:0]   ug = 32'h0;
    logic          prep = 1'b0;
    logic          line1 = 1'b0;
    logic          req = 1'b0;
    aabf_kind_type kind = KIND_TIMECODE;
    logic [5:0]    idx = 6'h00;
    logic [3:0]    seq = 4'h0;
    logic          svalid = 1'b0;
    logic [2:0]    schan = 3'h0;
    logic [15:0]   sample = 16'h0;
    logic          pready, pslverr, pvalid, avalid, afirst, aend, emph;
    logic [31:0]   prdata, rd;
    logic [39:0]   pdata;
    logic [2:0]    psect, achan, asect;
    logic [15:0]   adata;
    logic [1:0]    first_u, second_u, f;
    logic          err;
    int            n_fail = 0;
    int            n_checks = 0;
    int            n_frames = 0;
    int            j;

    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;

    aabf_formatter i_aabf_formatter (
        .clk_sys_in(clk_sys), .rst_n_in(rst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pready_out(pready), .pslverr_out(pslverr),
        .prdata_out(prdata), .frame_start_in(frame_start),
        .timecode_in(tc), .user_groups_in(ug), .picture_repeat_in(prep),
        .line1_start_in(line1), .pack_req_in(req), .pack_kind_in(kind),
        .pack_index_in(idx), .seq_num_in(seq), .pack_valid_out(pvalid),
        .pack_data_out(pdata), .pack_section_out(psect),
        .sample_valid_in(svalid), .sample_chan_in(schan),
        .sample_in(sample), .audio_valid_out(avalid),
        .audio_chan_out(achan), .audio_data_out(adata),
        .audio_first_out(afirst), .audio_block_end_out(aend),
        .audio_section_out(asect), .emphasis_out(emph));

    aabf_receiver i_aabf_receiver (
        .clk_sys_in(clk_sys), .pack_valid_in(pvalid),
        .pack_data_in(pdata), .first_unit_out(first_u),
        .second_unit_out(second_u));

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // Setup then access; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pk(input aabf_kind_type k, input logic [5:0] i,
                      input logic [3:0] s);
        @(posedge clk_sys);
        req <= 1'b1;
        kind <= k;
        idx <= i;
        seq <= s;
        @(posedge clk_sys);
        req <= 1'b0;
        #1;
    endtask

    task automatic frame(input logic rep);
        @(posedge clk_sys);
        frame_start <= 1'b1;
        prep <= rep;
        @(posedge clk_sys);
        frame_start <= 1'b0;
        n_frames++;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Run is a couple of hundred cycles; cut a hang well beyond that
    initial begin
        #50000;
        n_fail++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(emph, 1'b0);
        apb(1'b0, ADDR_CONFIG, 32'h0);
        chk(rd, 32'h1C00);
        apb(1'b1, ADDR_STATUS, 32'hFFFF);
        apb(1'b0, 8'h08, 32'h0);
        chk({err, rd}, 33'h1_0000_0000);
        apb(1'b1, ADDR_CONFIG, 32'h1D78);
        tc <= aabf_tc_type'{2'h1, 4'h2, 3'h3, 4'h4, 3'h5, 4'h6, 2'h2, 4'h3};
        ug <= 32'h8765_4321;
        frame(1'b1);
        // Table rows issued back to back, each checked one cycle later
        for (int r = 0; r <= 13; r++) begin
            @(posedge clk_sys);
            req <= (r < 13);
            if (r < 13) begin
                kind <= ROWS[r].k;
                idx <= ROWS[r].i;
                seq <= ROWS[r].s;
            end
            #1;
            if (r > 0) begin
                chk(pvalid, 1'b1);
                chk(pdata, ROWS[r-1].e);
                chk(psect, ROWS[r-1].c);
            end
        end
        // New input without a frame start must not leak into packs
        tc <= '0;
        ug <= 32'h0;
        pk(KIND_TIMECODE, 6'h00, 4'h3);
        chk(pdata, TCP);
        pk(KIND_USER_GROUP, 6'h00, 4'h4);
        chk(pdata, UGP);
        frame(1'b0);
        pk(KIND_TIMECODE, 6'h00, 4'h9);
        chk(pdata, 40'h13_C080_8080);
        // Rate, line format and delivery order combinations
        for (int m = 0; m < 5; m++) begin
            f = 2'(m % 4);
            apb(1'b1, ADDR_CONFIG, 32'h400 + 32'(f) * 32'h800 + 32'(MODES[m]));
            pk(KIND_TIMECODE, 6'h00, 4'h3);
            chk(pdata, 40'h13_0000_0000);
            pk(KIND_VIDEO_AUX_SECTION, VS_IDX_EVEN, 4'h0);
            chk(pdata, {HDR_VSOURCE, 16'hFFFF, 2'h3, MODES[m][0], STY[m],
                        8'h7F});
            pk(KIND_VIDEO_AUX_SECTION, VS_IDX_ODD, MODES[m][0] ? 4'hB : 4'h9);
            chk(pdata[39:32], HDR_VSOURCE);
            pk(KIND_VIDEO_AUX_SECTION, VSC_IDX_EVEN, 4'hA);
            chk(pdata[39:32], MODES[m][0] ? HDR_VSCTRL : BYTE_FILL);
            pk(KIND_VIDEO_AUX_SECTION, VSC_IDX_EVEN, 4'h0);
            chk(pdata, {HDR_VSCTRL, 16'h3FCA, f[0], f[1], 14'h3CFF});
            @(posedge clk_sys);
            #1;
            chk(first_u, f[1] ? 2'h1 : 2'h2);
            chk(second_u, (f[0] ^ f[1]) ? 2'h1 : 2'h2);
        end
        apb(1'b1, ADDR_CONFIG, 32'h1800);
        pk(KIND_VIDEO_AUX_SECTION, VS_IDX_EVEN, 4'h0);
        chk(pdata, PACK_EMPTY);
        apb(1'b1, ADDR_CONFIG, 32'h1E00);
        #1;
        chk(emph, 1'b1);
        // Two channels interleaved, error code first on each
        @(posedge clk_sys);
        line1 <= 1'b1;
        @(posedge clk_sys);
        line1 <= 1'b0;
        for (int k = 0; k <= 72; k++) begin
            @(posedge clk_sys);
            svalid <= (k < 72);
            schan <= (k % 2) ? 3'h5 : 3'h2;
            sample <= (k < 2) ? SAMPLE_ERROR : 16'(k * 257);
            #1;
            if (k > 0) begin
                j = k - 1;
                chk(avalid, 1'b1);
                chk(achan, (j % 2) ? 3'h5 : 3'h2);
                chk(adata, (j < 2) ? SAMPLE_SUBST : 16'(j * 257));
                chk(afirst, j < 2);
                chk(aend, j >= 70);
                chk(asect, SECT_AUDIO);
            end
        end
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, {16'(n_frames), 16'h0002});
        // Reset in mid-run brings the configuration back to default
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(emph, 1'b0);
        chk(pvalid, 1'b0);
        apb(1'b0, ADDR_CONFIG, 32'h0);
        chk(rd, 32'h1C00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
